// ---- core/lockup_supervisor.sv ----
// lockup supervisor: index/data port configuration, countdown and reset output
//
// How it works
// - countdown expiry without reload drives the system reset output.
// - timeout programmable from 1 to 255 units, in one-second or one-minute steps.
// - expiry never comes early, as each load restarts the time base; software reloads earlier.
// - index port at the lower address, data port at the next one.
// - two key bytes in a row on the index port unlock configuration.
// - the exit byte on the index port relocks configuration.
// - routing value in pin route register puts reset on supervisor_reset_pin.
// - logical device eight selected makes supervisor registers visible.
// - writing one to activate register enables the supervisor.
// - time unit zero counts in seconds.
// - nonzero count write loads that many units and starts counting.
// - zero count write halts the countdown; no reset follows.
// - nonzero write while running restarts from the new value.
`timescale 1ns/100ps
module lockup_supervisor #(
  parameter longint TICK_CYCLES = lockup_supervisor_pkg::TICK_CYCLES,
  parameter longint RESET_PULSE_CYCLES = lockup_supervisor_pkg::RESET_PULSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic alt_pin_out,
  output logic supervisor_reset_pin,
  output logic supervisor_expired,
  output logic countdown_running
);
  import lockup_supervisor_pkg::*;

  localparam int PW = (RESET_PULSE_CYCLES > 2) ? $clog2(RESET_PULSE_CYCLES + 1) : 2;
  localparam logic [PW-1:0] PULSE_LOAD = PW'(RESET_PULSE_CYCLES);

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  if (RESET_PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("lockup_supervisor: RESET_PULSE_CYCLES must be at least 1");
  end

  // true when the index names a register of the selected supervisor device
  function automatic logic dev_hit(input logic [7:0] ldn, input logic [7:0] idx,
                                   input logic [7:0] want);
    dev_hit = (ldn == LDN_SUPERVISOR) && (idx == want);
  endfunction : dev_hit

  // --------------------------------------------------------------
  // port decode
  // --------------------------------------------------------------
  logic wr_index;
  logic wr_data;
  logic rd_data;

  assign wr_index = io_wr && (io_addr == INDEX_PORT_ADDR);
  assign wr_data = io_wr && (io_addr == DATA_PORT_ADDR);
  assign rd_data = io_rd && (io_addr == DATA_PORT_ADDR);

  // --------------------------------------------------------------
  // configuration state and registers
  // --------------------------------------------------------------
  cfg_state_type cfg_ff;
  cfg_state_type nxt_cfg;
  logic [7:0] index_ff;
  logic [7:0] nxt_index;
  logic [7:0] ldn_ff;
  logic [7:0] nxt_ldn;
  logic [7:0] route_ff;
  logic [7:0] nxt_route;
  logic [7:0] activate_ff;
  logic [7:0] nxt_activate;
  logic [7:0] unit_ff;
  logic [7:0] nxt_unit;
  logic cfg_open;
  logic count_wr;

  assign cfg_open = (cfg_ff == CFG_UNLOCKED);
  // a data write only counts once the key sequence has opened access
  assign count_wr = wr_data && cfg_open
                    && dev_hit(ldn_ff, index_ff, IDX_COUNTDOWN_VALUE);

  // key sequence, index latch and register writes
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_index = index_ff;
    nxt_ldn = ldn_ff;
    nxt_route = route_ff;
    nxt_activate = activate_ff;
    nxt_unit = unit_ff;
    if (wr_index) begin
      case (cfg_ff)
        CFG_LOCKED: begin
          nxt_cfg = (io_wdata == KEY_ENTER) ? CFG_KEY_SEEN : CFG_LOCKED;
        end
        CFG_KEY_SEEN: begin
          nxt_cfg = (io_wdata == KEY_ENTER) ? CFG_UNLOCKED : CFG_LOCKED;
        end
        CFG_UNLOCKED: begin
          if (io_wdata == KEY_EXIT) begin
            nxt_cfg = CFG_LOCKED;
          end else begin
            nxt_index = io_wdata;
          end
        end
        default: begin
          nxt_cfg = CFG_LOCKED;
        end
      endcase
    end
    if (wr_data && cfg_open) begin
      if (index_ff == IDX_LOGICAL_DEVICE_SELECT) begin
        nxt_ldn = io_wdata;
      end
      if (index_ff == IDX_PIN_FUNCTION_ROUTE) begin
        nxt_route = io_wdata;
      end
      if (dev_hit(ldn_ff, index_ff, IDX_DEVICE_ACTIVATE)) begin
        nxt_activate = io_wdata;
      end
      if (dev_hit(ldn_ff, index_ff, IDX_COUNTDOWN_TIME_UNIT)) begin
        nxt_unit = io_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= CFG_LOCKED;
      index_ff <= REG_RESET;
      ldn_ff <= REG_RESET;
      route_ff <= REG_RESET;
      activate_ff <= REG_RESET;
      unit_ff <= UNIT_SECONDS;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      index_ff <= nxt_index;
      ldn_ff <= nxt_ldn;
      route_ff <= nxt_route;
      activate_ff <= nxt_activate;
      unit_ff <= nxt_unit;
    end
  end

  // --------------------------------------------------------------
  // time base
  // --------------------------------------------------------------
  logic sec_tick;

  // each count load restarts the second divider, so the full period is kept
  second_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .restart(count_wr),
    .tick(sec_tick)
  );

  // --------------------------------------------------------------
  // countdown and reset pulse
  // --------------------------------------------------------------
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [5:0] minute_ff;
  logic [5:0] nxt_minute;
  logic [PW-1:0] pulse_ff;
  logic [PW-1:0] nxt_pulse;
  logic expired_ff;
  logic nxt_expired;
  logic unit_tick;
  logic active;

  assign active = activate_ff[ACTIVATE_BIT];
  // any unit other than seconds is taken as minutes, from a 60-second prescale
  assign unit_tick = sec_tick
                     && ((unit_ff == UNIT_SECONDS) || (minute_ff == SECONDS_PER_MINUTE - 6'h01));

  always_comb begin
    nxt_count = count_ff;
    nxt_minute = minute_ff;
    nxt_pulse = pulse_ff;
    nxt_expired = expired_ff;
    if (pulse_ff != '0) begin
      nxt_pulse = pulse_ff - 1'b1;
    end
    if (count_wr) begin
      // load wins over a tick landing in the same cycle
      nxt_count = io_wdata;
      nxt_minute = '0;
      nxt_expired = 1'b0;
    end else if (active && (count_ff != COUNT_STOP) && sec_tick) begin
      nxt_minute = (minute_ff == SECONDS_PER_MINUTE - 6'h01) ? 6'h00 : minute_ff + 6'h01;
      if (unit_tick) begin
        nxt_count = count_ff - 8'h01;
        if (count_ff == 8'h01) begin
          nxt_pulse = PULSE_LOAD;
          nxt_expired = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= COUNT_STOP;
      minute_ff <= '0;
      pulse_ff <= '0;
      expired_ff <= 1'b0;
    end else if (ce) begin
      count_ff <= nxt_count;
      minute_ff <= nxt_minute;
      pulse_ff <= nxt_pulse;
      expired_ff <= nxt_expired;
    end
  end

  // --------------------------------------------------------------
  // pin routing and status outputs
  // --------------------------------------------------------------
  logic pin_ff;
  logic nxt_pin;
  logic running_ff;
  logic nxt_running;

  // without the routing value the pin keeps its alternate use
  always_comb begin
    nxt_pin = (route_ff == ROUTE_SUPERVISOR) ? (nxt_pulse != '0) : alt_pin_out;
    nxt_running = active && (nxt_count != COUNT_STOP);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_ff <= 1'b0;
      running_ff <= 1'b0;
    end else if (ce) begin
      pin_ff <= nxt_pin;
      running_ff <= nxt_running;
    end
  end

  assign supervisor_reset_pin = pin_ff;
  assign supervisor_expired = expired_ff;
  assign countdown_running = running_ff;

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // the count register reads back the live remaining count
  always_comb begin
    nxt_rdata = rdata_ff;
    if (io_rd && (io_addr == INDEX_PORT_ADDR)) begin
      nxt_rdata = cfg_open ? index_ff : LOCKED_READ_VALUE;
    end else if (rd_data) begin
      nxt_rdata = REG_RESET;
      if (!cfg_open) begin
        nxt_rdata = LOCKED_READ_VALUE;
      end else if (index_ff == IDX_LOGICAL_DEVICE_SELECT) begin
        nxt_rdata = ldn_ff;
      end else if (index_ff == IDX_PIN_FUNCTION_ROUTE) begin
        nxt_rdata = route_ff;
      end else if (dev_hit(ldn_ff, index_ff, IDX_DEVICE_ACTIVATE)) begin
        nxt_rdata = activate_ff;
      end else if (dev_hit(ldn_ff, index_ff, IDX_COUNTDOWN_TIME_UNIT)) begin
        nxt_rdata = unit_ff;
      end else if (dev_hit(ldn_ff, index_ff, IDX_COUNTDOWN_VALUE)) begin
        nxt_rdata = count_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= REG_RESET;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign io_rdata = rdata_ff;

endmodule : lockup_supervisor

// ---- core/lockup_supervisor_pkg.sv ----
// constants and types shared by the lockup supervisor and its tick source
package lockup_supervisor_pkg;

  // --------------------------------------------------------------
  // host i/o port addresses and access keys
  // --------------------------------------------------------------
  localparam logic [15:0] INDEX_PORT_ADDR = 16'h002e;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h002f;
  localparam logic [7:0] KEY_ENTER = 8'h87;
  localparam logic [7:0] KEY_EXIT = 8'haa;

  // --------------------------------------------------------------
  // configuration register indexes
  // --------------------------------------------------------------
  localparam logic [7:0] IDX_LOGICAL_DEVICE_SELECT = 8'h07;
  localparam logic [7:0] IDX_PIN_FUNCTION_ROUTE = 8'h2b;
  localparam logic [7:0] IDX_DEVICE_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_COUNTDOWN_TIME_UNIT = 8'hf5;
  localparam logic [7:0] IDX_COUNTDOWN_VALUE = 8'hf6;

  // --------------------------------------------------------------
  // field values, positions and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] LDN_SUPERVISOR = 8'h08;
  localparam logic [7:0] ROUTE_SUPERVISOR = 8'h0d;
  localparam int ACTIVATE_BIT = 0;
  localparam logic [7:0] UNIT_SECONDS = 8'h00;
  localparam logic [7:0] COUNT_STOP = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [7:0] LOCKED_READ_VALUE = 8'hff;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint TICK_PERIOD_NS = 1000000000;
  localparam longint TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam longint RESET_PULSE_NS = 1000;
  localparam longint RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3c;

  // configuration access state
  typedef enum logic [1:0] {
    CFG_LOCKED,
    CFG_KEY_SEEN,
    CFG_UNLOCKED
  } cfg_state_type;

endpackage : lockup_supervisor_pkg

// ---- core/second_tick_gen.sv ----
// free-running time-base tick generator with a restart input
`timescale 1ns/100ps
module second_tick_gen #(
  parameter longint TICK_CYCLES = lockup_supervisor_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic restart,
  output logic tick
);
  import lockup_supervisor_pkg::*;

  localparam int CW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("second_tick_gen: TICK_CYCLES must be at least 2");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // --------------------------------------------------------------
  // divider
  // --------------------------------------------------------------
  // a restart realigns the phase so a fresh load runs a full period
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (restart) begin
      nxt_cnt = '0;
    end else if (cnt_ff == LAST) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : second_tick_gen

// ---- testbench/io_host_model.sv ----
// host processor model issuing index/data port cycles
`timescale 1ns/100ps
module io_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] io_rdata,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  import lockup_supervisor_pkg::*;
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one write per call; back-to-back calls make back-to-back cycles
  task automatic port_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    io_rd = 1'b0;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
  endtask : port_wr
  // released lines show the inverse so stale values never look valid
  task automatic idle();
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : idle
  task automatic port_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_addr = a;
    io_rd = 1'b1;
    @(negedge sys_clk);
    io_rd = 1'b0;
    d = io_rdata;
    io_addr = ~io_addr;
  endtask : port_rd
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    port_wr(INDEX_PORT_ADDR, idx);
    port_wr(DATA_PORT_ADDR, d);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    port_wr(INDEX_PORT_ADDR, idx);
    port_rd(DATA_PORT_ADDR, d);
  endtask : reg_rd
  task automatic open_cfg(input logic [7:0] ldn);
    port_wr(INDEX_PORT_ADDR, KEY_ENTER);
    port_wr(INDEX_PORT_ADDR, KEY_ENTER);
    reg_wr(IDX_LOGICAL_DEVICE_SELECT, ldn);
  endtask : open_cfg
  task automatic close_cfg();
    port_wr(INDEX_PORT_ADDR, KEY_EXIT);
    idle();
  endtask : close_cfg
  // caller spaces reloads well inside the timeout
  task automatic load_count(input logic [7:0] n);
    open_cfg(LDN_SUPERVISOR);
    reg_wr(IDX_COUNTDOWN_VALUE, n);
    close_cfg();
  endtask : load_count
endmodule : io_host_model

// ---- testbench/lockup_supervisor_props.sv ----
// concurrent checks on the lockup supervisor ports
`timescale 1ns/100ps
module lockup_supervisor_props #(
  parameter longint TICK_CYCLES = 20,
  parameter longint RESET_PULSE_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic alt_pin_out,
  input wire logic supervisor_reset_pin,
  input wire logic supervisor_expired,
  input wire logic countdown_running
);
  logic [15:0] pulse_cnt_ff;
  logic [15:0] nxt_pulse_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // helper: width of the current reset pulse
  // ----------------------------------------
  always_comb begin
    nxt_pulse_cnt = supervisor_reset_pin ? pulse_cnt_ff + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt_ff <= 16'h0000;
    end else begin
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end
  sequence expiry_seq;
    $rose(supervisor_expired);
  endsequence
  sequence pulse_start_seq;
    supervisor_reset_pin ##1 supervisor_reset_pin;
  endsequence
  a_pulse_start: assert property (expiry_seq |-> pulse_start_seq)
    else $error("reset pin not raised at expiry");
  a_pulse_width: assert property ($fell(supervisor_reset_pin) && supervisor_expired
    |-> pulse_cnt_ff == RESET_PULSE_CYCLES) else $error("reset pulse width wrong");
  a_expire_stops_run: assert property (expiry_seq |-> !countdown_running)
    else $error("still running after expiry");
  a_expire_after_run: assert property (expiry_seq |-> $past(countdown_running))
    else $error("expiry without a running count");
  a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
  a_expired_sticky: assert property (supervisor_expired && !io_wr |=> supervisor_expired)
    else $error("expired flag lost without a write");
  a_ce_freeze: assert property (!ce
    |=> $stable(countdown_running) && $stable(supervisor_expired))
    else $error("state moved with clock enable low");
  a_start_by_write: assert property ($rose(countdown_running) |-> $past(io_wr))
    else $error("countdown started without a write");
  a_stop_cause: assert property ($fell(countdown_running)
    |-> $past(io_wr) || supervisor_expired)
    else $error("countdown stopped without cause");
endmodule : lockup_supervisor_props

bind lockup_supervisor lockup_supervisor_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) chk_u (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .alt_pin_out(alt_pin_out),
  .supervisor_reset_pin(supervisor_reset_pin), .supervisor_expired(supervisor_expired),
  .countdown_running(countdown_running));

// ---- testbench/test_io_port_watchdog_timer.sv ----
// self-checking bench for the io port watchdog timer
`timescale 1ns/100ps
module test_io_port_watchdog_timer;
  import lockup_supervisor_pkg::*;
  localparam longint TICKS = 20;
  localparam longint PULSE = 4;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic alt_pin_out = 1'b0;
  logic [15:0] io_addr;
  logic io_wr, io_rd;
  logic [7:0] io_wdata, io_rdata, d;
  logic supervisor_reset_pin, supervisor_expired, countdown_running;
  logic [15:0] outs;
  // all outputs in one word, zero after any reset
  assign outs = {io_rdata, 5'h00, supervisor_reset_pin, supervisor_expired, countdown_running};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc;
  always #5 sys_clk = ~sys_clk;
  lockup_supervisor #(.TICK_CYCLES(TICKS), .RESET_PULSE_CYCLES(PULSE)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .alt_pin_out(alt_pin_out),
    .supervisor_reset_pin(supervisor_reset_pin), .supervisor_expired(supervisor_expired),
    .countdown_running(countdown_running));
  io_host_model host_u (.sys_clk(sys_clk), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  // ------------------------------
  // shared helpers
  // ------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_pin(output int c);
    c = 0;
    while (supervisor_reset_pin !== 1'b1 && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : wait_pin
  function automatic logic [15:0] in_win(int c, longint lo, longint hi);
    return {15'h0000, (c >= lo && c <= hi)};
  endfunction : in_win
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    check(outs, 16'h0000);
    alt_pin_out = ~alt_pin_out;
    repeat (3) @(negedge sys_clk);
    check({15'h0000, supervisor_reset_pin}, 16'h0001);
    alt_pin_out = ~alt_pin_out;
    repeat (3) @(negedge sys_clk);
    check({15'h0000, supervisor_reset_pin}, 16'h0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_setup();
    host_u.open_cfg(LDN_SUPERVISOR);
    host_u.reg_wr(IDX_PIN_FUNCTION_ROUTE, ROUTE_SUPERVISOR);
    host_u.reg_wr(IDX_DEVICE_ACTIVATE, 8'h01);
    host_u.reg_wr(IDX_COUNTDOWN_TIME_UNIT, UNIT_SECONDS);
    host_u.reg_rd(IDX_PIN_FUNCTION_ROUTE, d);
    check({8'h00, d}, {8'h00, ROUTE_SUPERVISOR});
    host_u.reg_rd(IDX_DEVICE_ACTIVATE, d);
    check({8'h00, d}, 16'h0001);
    host_u.reg_rd(8'h55, d);
    check({8'h00, d}, 16'h0000);
    host_u.close_cfg();
    host_u.reg_rd(IDX_PIN_FUNCTION_ROUTE, d);
    check({8'h00, d}, {8'h00, LOCKED_READ_VALUE});
    $display("t_setup done");
  endtask : t_setup
  task automatic t_locked();
    host_u.reg_wr(IDX_COUNTDOWN_VALUE, 8'h05);
    host_u.idle();
    check({15'h0000, countdown_running}, 16'h0000);
    host_u.open_cfg(8'h05);
    host_u.reg_wr(IDX_COUNTDOWN_VALUE, 8'h05);
    host_u.close_cfg();
    check({15'h0000, countdown_running}, 16'h0000);
    $display("t_locked done");
  endtask : t_locked
  task automatic t_expire();
    host_u.load_count(8'h03);
    check({15'h0000, countdown_running}, 16'h0001);
    wait_pin(cyc);
    check(in_win(cyc, 3 * TICKS, 3 * TICKS + 3), 16'h0001);
    check({14'h0000, supervisor_expired, countdown_running}, 16'h0002);
    cyc = 0;
    while (supervisor_reset_pin === 1'b1 && cyc < 50) begin
      @(negedge sys_clk);
      cyc++;
    end
    check(cyc[15:0], PULSE[15:0]);
    $display("t_expire done");
  endtask : t_expire
  task automatic t_reload();
    host_u.load_count(8'h03);
    check({15'h0000, supervisor_expired}, 16'h0000);
    repeat (TICKS + 5) @(negedge sys_clk);
    host_u.open_cfg(LDN_SUPERVISOR);
    host_u.reg_rd(IDX_COUNTDOWN_VALUE, d);
    host_u.close_cfg();
    check({8'h00, d}, 16'h0002);
    host_u.load_count(8'h03);
    wait_pin(cyc);
    check(in_win(cyc, 3 * TICKS, 3 * TICKS + 3), 16'h0001);
    $display("t_reload done");
  endtask : t_reload
  task automatic t_stop();
    host_u.load_count(8'h02);
    host_u.load_count(COUNT_STOP);
    check({15'h0000, countdown_running}, 16'h0000);
    repeat (3 * TICKS) @(negedge sys_clk);
    check({14'h0000, supervisor_reset_pin, supervisor_expired}, 16'h0000);
    $display("t_stop done");
  endtask : t_stop
  // frozen clock enable must hold the count, then the expiry resumes
  task automatic t_ce();
    host_u.load_count(8'h01);
    ce = 1'b0;
    repeat (3 * TICKS) @(negedge sys_clk);
    check({14'h0000, supervisor_reset_pin, countdown_running}, 16'h0001);
    ce = 1'b1;
    wait_pin(cyc);
    check(in_win(cyc, TICKS - 3, TICKS + 3), 16'h0001);
    $display("t_ce done");
  endtask : t_ce
  // minutes time base; a routed pin must ignore its alternate level meanwhile
  task automatic t_units();
    host_u.open_cfg(LDN_SUPERVISOR);
    host_u.reg_wr(IDX_COUNTDOWN_TIME_UNIT, 8'h01);
    host_u.close_cfg();
    host_u.load_count(8'h01);
    alt_pin_out = ~alt_pin_out;
    wait_pin(cyc);
    check(in_win(cyc, SECONDS_PER_MINUTE * TICKS, SECONDS_PER_MINUTE * TICKS + 3), 16'h0001);
    alt_pin_out = ~alt_pin_out;
    $display("t_units done");
  endtask : t_units
  // reset in mid-countdown clears all state and relocks the ports
  task automatic t_midreset();
    host_u.load_count(8'h02);
    repeat (TICKS + 5) @(negedge sys_clk);
    rstn = 1'b0;
    @(negedge sys_clk);
    check(outs, 16'h0000);
    rstn = 1'b1;
    repeat (2) begin
      @(negedge sys_clk);
      check(outs, 16'h0000);
    end
    repeat (3 * TICKS) @(negedge sys_clk);
    check({14'h0000, supervisor_reset_pin, countdown_running}, 16'h0000);
    host_u.reg_rd(IDX_COUNTDOWN_VALUE, d);
    check({8'h00, d}, {8'h00, LOCKED_READ_VALUE});
    $display("t_midreset done");
  endtask : t_midreset
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // watchdog: the whole sequence needs about 1700 cycles, the limit is 20000
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    t_reset();
    t_setup();
    t_locked();
    t_expire();
    t_reload();
    t_stop();
    t_ce();
    t_units();
    t_midreset();
    results();
  end
endmodule : test_io_port_watchdog_timer
